/* File: core/cis_pkg.sv */
package cis_pkg;

  // reset state of the programmer's model
  localparam logic [15:0] RESET_PC = 16'h0000;
  localparam logic [7:0] RESET_SP = 8'hff;
  localparam logic [7:0] RESET_PSW = 8'h00;
  // stack lives in page one, trap vector near the top of memory
  localparam logic [7:0] STACK_PAGE = 8'h01;
  localparam logic [15:0] TRAP_VEC = 16'hffde;
  // core clocks per machine cycle and taken-branch penalty
  localparam int MCYC_CLKS = 4;
  localparam logic [3:0] BR_EXTRA = 4'h2;
  // status word bit positions
  localparam int F_N = 7;
  localparam int F_V = 6;
  localparam int F_G = 5;
  localparam int F_B = 4;
  localparam int F_H = 3;
  localparam int F_I = 2;
  localparam int F_Z = 1;
  localparam int F_C = 0;
  // register bus map and reset of the control word
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_STAT = 12'h004;
  localparam logic [11:0] REG_CORE = 12'h008;
  localparam logic CTRL_RUN_RST = 1'b1;

  // sequencer states
  typedef enum logic [3:0]
  {
    S_FETCH = 4'h0, S_OPC = 4'h1, S_OP1 = 4'h2, S_OP2 = 4'h3,
    S_ADR = 4'h4, S_RD = 4'h5, S_EXEC = 4'h6, S_WR = 4'h7,
    S_WAIT = 4'h8, S_STOP = 4'h9
  } cis_state_type;

  // one memory request, held for a single cycle
  typedef struct packed
  {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic we;
    logic re;
  } cis_memreq_type;

  // opcode shape: bytes, data reads, base machine cycles
  typedef struct packed
  {
    logic [1:0] len;
    logic [1:0] nrd;
    logic [3:0] cyc;
  } cis_dec_type;

  // whole core state, registered as one word
  typedef struct packed
  {
    cis_state_type state;
    logic [15:0] pc;
    logic [7:0] a, x, y, sp, status_word, opc, b1, b2;
    logic [2:0][7:0] d;
    logic [2:0][15:0] wa;
    logic [2:0][7:0] wd;
    logic [1:0] nwr, idx;
    logic [3:0] tgt;
    logic [5:0] clk;
    logic stop, halt;
    cis_memreq_type mem;
  } cis_cpu_type;

  localparam cis_cpu_type CPU_RST = '{state: S_FETCH, pc: RESET_PC,
    sp: RESET_SP, status_word: RESET_PSW, default: '0};

endpackage : cis_pkg

/* File: core/cis_core.sv */
`timescale 1ns/10ps
module cis_core
  import cis_pkg::*;
#(
  parameter int MCYC = MCYC_CLKS  // core clocks per machine cycle
)
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output cis_memreq_type memReq,
  input wire logic [7:0] memRdata,
  output logic oscStop
);

  ////////////////////////////////////////////////////////////////////////
  // helpers

  // shape of each opcode; unknown codes run as a two-cycle no-op
  function automatic cis_dec_type cisDecode(input logic [7:0] op);
    casez (op)
      8'hfb: cisDecode = '{2'd1, 2'd0, 4'd4};
      8'h5b: cisDecode = '{2'd1, 2'd0, 4'd9};
      8'hce: cisDecode = '{2'd1, 2'd0, 4'd5};
      8'hef: cisDecode = '{2'd1, 2'd0, 4'd3};
      8'h0f: cisDecode = '{2'd1, 2'd2, 4'd8};
      8'h7f: cisDecode = '{2'd1, 2'd3, 4'd6};
      8'h34: cisDecode = '{2'd1, 2'd1, 4'd3};
      8'h24, 8'hc4, 8'h1e, 8'h3e: cisDecode = '{2'd2, 2'd0, 4'd2};
      8'h2f, 8'h7b: cisDecode = '{2'd2, 2'd0, 4'd4};
      8'ha9, 8'h89, 8'h49, 8'h29, 8'h69, 8'h26, 8'h0c:
        cisDecode = '{2'd2, 2'd1, 4'd4};
      8'hb9, 8'h99: cisDecode = '{2'd2, 2'd1, 4'd5};
      8'h25: cisDecode = '{2'd2, 2'd1, 4'd3};
      8'h1d: cisDecode = '{2'd2, 2'd2, 4'd5};
      8'h5d: cisDecode = '{2'd2, 2'd2, 4'd4};
      8'h5f: cisDecode = '{2'd2, 2'd2, 4'd8};
      8'hb8, 8'h98, 8'h1c, 8'hfd, 8'hac: cisDecode = '{2'd3, 2'd1, 4'd5};
      8'h27, 8'h8b: cisDecode = '{2'd3, 2'd1, 4'd4};
      8'h5c, 8'h8d: cisDecode = '{2'd3, 2'd1, 4'd6};
      8'he4: cisDecode = '{2'd3, 2'd0, 4'd5};
      8'h3b: cisDecode = '{2'd3, 2'd0, 4'd8};
      8'b???10000: cisDecode = '{2'd2, 2'd0, 4'd2};
      8'h?2: cisDecode = '{2'd2, 2'd0, 4'd4};
      8'h?3: cisDecode = '{2'd3, 2'd1, 4'd5};
      default: cisDecode = '{2'd1, 2'd0, 4'd2};
    endcase
  endfunction : cisDecode

  // update N and Z from a byte, other bits untouched
  function automatic logic [7:0] nzf(input logic [7:0] p,
                                     input logic [7:0] v);
    nzf = p;
    nzf[F_N] = v[7];
    nzf[F_Z] = (v == 8'h00);
  endfunction : nzf

  // a one-cycle read request
  function automatic cis_memreq_type rdReq(input logic [15:0] ad);
    rdReq = '{addr: ad, wdata: 8'h00, we: 1'b0, re: 1'b1};
  endfunction : rdReq

  ////////////////////////////////////////////////////////////////////////
  // register bus: control word, status, core view

  logic runEn_r, runEn_nxt;  // software run enable, gates fetch
  logic pready_r, pready_nxt;  // one wait state, then answer
  logic pslverr_r, pslverr_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  cis_cpu_type cpu_r, n;  // core state and its next value

  // answer in the second access cycle; writes land on the edge that ends it
  always_comb
  begin
    runEn_nxt = runEn_r;
    pready_nxt = psel && penable && !pready_r;
    pslverr_nxt = 1'b0;
    prdata_nxt = 32'h0000_0000;
    if (pready_nxt)
    begin
      case (paddr)
        REG_CTRL: prdata_nxt = {31'h0000_0000, runEn_r};
        REG_STAT: prdata_nxt = {15'h0000, cpu_r.halt, cpu_r.pc};
        REG_CORE: prdata_nxt = {cpu_r.status_word, cpu_r.y, cpu_r.x, cpu_r.a};
        // unmapped offsets answer with an error
        default: pslverr_nxt = 1'b1;
      endcase
    end
    if (psel && penable && pready_r && pwrite && paddr == REG_CTRL)
    begin
      runEn_nxt = pwdata[0];
    end
  end

  // bus registers
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      runEn_r <= CTRL_RUN_RST;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end
    else
    begin
      runEn_r <= runEn_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      prdata_r <= prdata_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;

  ////////////////////////////////////////////////////////////////////////
  // instruction sequencer

  cis_dec_type dc, dn;  // shape of held opcode and of incoming byte
  logic [7:0] op, pg, src, res8, rel;  // opcode, page, operand, result
  logic [15:0] ea, ra, wdp;  // effective, read and word-operand values
  logic [1:0] rIdx;  // index of the read being issued
  logic [8:0] s9;
  logic [4:0] h5;
  logic [16:0] s17;
  logic [12:0] h13;
  logic [15:0] p16;
  logic taken, bitv, st8;
  logic [5:0] lim;  // last core clock of this instruction

  // next core state; memory requests are single-cycle pulses
  always_comb
  begin
    n = cpu_r;
    n.mem = '0;
    n.clk = cpu_r.clk + 6'd1;
    op = cpu_r.opc;
    dc = cisDecode(op);
    dn = cisDecode(memRdata);
    pg = {7'h00, cpu_r.status_word[F_G]};
    wdp = {cpu_r.d[1], cpu_r.d[0]};
    s9 = '0;
    h5 = '0;
    s17 = '0;
    h13 = '0;
    p16 = '0;
    taken = 1'b0;
    bitv = 1'b0;
    st8 = 1'b0;
    res8 = 8'h00;
    rel = cpu_r.b2;
    lim = 6'(32'(cpu_r.tgt) * MCYC - 1);
    rIdx = (cpu_r.state == S_ADR) ? 2'd0 : cpu_r.idx + 2'd1;
    // addressing modes
    case (op)
      8'hb9, 8'h99, 8'h26, 8'h8d: ea = {pg, cpu_r.b1 + cpu_r.x};
      8'hb8, 8'h98, 8'h27, 8'h1c, 8'h5c: ea = {cpu_r.b2, cpu_r.b1};
      // bit address: low byte, then high nibble in the second byte
      8'h8b: ea = {4'h0, cpu_r.b2[3:0], cpu_r.b1};
      8'h34: ea = {pg, cpu_r.x};
      default: ea = {pg, cpu_r.b1};
    endcase
    // read addresses for vectors, pops and word operands
    case (op)
      8'h0f: ra = TRAP_VEC + {14'h0000, rIdx};
      8'h7f: ra = {STACK_PAGE, cpu_r.sp + 8'h01 + {6'h00, rIdx}};
      8'h1d, 8'h5d, 8'h5f: ra = {pg, cpu_r.b1 + {6'h00, rIdx}};
      default: ra = ea;
    endcase
    // operand source for one-byte operations
    case (op)
      8'ha8, 8'h88, 8'h48, 8'h28, 8'h68: src = cpu_r.a;
      8'haf, 8'h8f: src = cpu_r.x;
      8'hbe, 8'h9e: src = cpu_r.y;
      8'h24, 8'hc4, 8'h1e, 8'h3e: src = cpu_r.b1;
      default: src = cpu_r.d[0];
    endcase
    case (cpu_r.state)
      // fetch stalls here while software holds the core stopped
      S_FETCH:
      begin
        n.clk = 6'd0;
        if (runEn_r)
        begin
          // the fetch clock is clock zero, so fetch to fetch is tgt * MCYC
          n.clk = 6'd1;
          n.mem = rdReq(cpu_r.pc);
          n.pc = cpu_r.pc + 16'h0001;
          n.state = S_OPC;
        end
      end
      S_OPC:
      begin
        n.opc = memRdata;
        n.state = S_ADR;
        if (dn.len != 2'd1)
        begin
          n.mem = rdReq(cpu_r.pc);
          n.pc = cpu_r.pc + 16'h0001;
          n.state = S_OP1;
        end
      end
      S_OP1:
      begin
        n.b1 = memRdata;
        n.state = S_ADR;
        if (dc.len == 2'd3)
        begin
          n.mem = rdReq(cpu_r.pc);
          n.pc = cpu_r.pc + 16'h0001;
          n.state = S_OP2;
        end
      end
      S_OP2:
      begin
        n.b2 = memRdata;
        n.state = S_ADR;
      end
      S_ADR:
      begin
        n.idx = 2'd0;
        n.state = S_EXEC;
        if (dc.nrd != 2'd0)
        begin
          n.mem = rdReq(ra);
          n.state = S_RD;
        end
      end
      // capture a data byte, issue the next one if any
      S_RD:
      begin
        n.d[cpu_r.idx] = memRdata;
        n.idx = cpu_r.idx + 2'd1;
        n.state = S_EXEC;
        if (rIdx < dc.nrd)
        begin
          n.mem = rdReq(ra);
          n.state = S_RD;
        end
      end
      // flags not named below are carried over by n = cpu_r
      S_EXEC:
      begin
        n.idx = 2'd0;
        n.nwr = 2'd0;
        casez (op)
          8'ha8, 8'haf, 8'hbe, 8'ha9, 8'hb9, 8'hb8:
          begin
            res8 = src - 8'h01;
            n.status_word = nzf(cpu_r.status_word, res8);
            st8 = 1'b1;
          end
          8'h88, 8'h8f, 8'h9e, 8'h89, 8'h99, 8'h98:
          begin
            s9 = {1'b0, src} + 9'h001;
            res8 = s9[7:0];
            n.status_word = nzf(cpu_r.status_word, res8);
            n.status_word[F_C] = s9[8];
            st8 = 1'b1;
          end
          8'h48, 8'h49:
          begin
            res8 = {1'b0, src[7:1]};
            n.status_word = nzf(cpu_r.status_word, res8);
            n.status_word[F_C] = src[0];
            st8 = 1'b1;
          end
          8'h28, 8'h29, 8'h68, 8'h69:
          begin
            res8 = op[6] ? {cpu_r.status_word[F_C], src[7:1]}
                         : {src[6:0], cpu_r.status_word[F_C]};
            n.status_word = nzf(cpu_r.status_word, res8);
            n.status_word[F_C] = op[6] ? src[0] : src[7];
            st8 = 1'b1;
          end
          // borrow subtract as A + ~M + C
          8'h24, 8'h25, 8'h26, 8'h27, 8'h34:
          begin
            s9 = {1'b0, cpu_r.a} + {1'b0, ~src} + {8'h00, cpu_r.status_word[F_C]};
            h5 = {1'b0, cpu_r.a[3:0]} + {1'b0, ~src[3:0]}
               + {4'h0, cpu_r.status_word[F_C]};
            n.a = s9[7:0];
            n.status_word = nzf(cpu_r.status_word, s9[7:0]);
            n.status_word[F_V] = (cpu_r.a[7] ^ src[7]) & (cpu_r.a[7] ^ s9[7]);
            n.status_word[F_H] = h5[4];
            n.status_word[F_C] = s9[8];
          end
          // immediate loads
          8'hc4:
          begin
            n.a = src;
            n.status_word = nzf(cpu_r.status_word, src);
          end
          8'h1e:
          begin
            n.x = src;
            n.status_word = nzf(cpu_r.status_word, src);
          end
          8'h3e:
          begin
            n.y = src;
            n.status_word = nzf(cpu_r.status_word, src);
          end
          // product in Y:A, N from bit 15
          8'h5b:
          begin
            p16 = 16'(cpu_r.y) * 16'(cpu_r.a);
            {n.y, n.a} = p16;
            n.status_word[F_N] = p16[15];
            n.status_word[F_Z] = (p16 == 16'h0000);
          end
          8'hce:
          begin
            n.a = {cpu_r.a[3:0], cpu_r.a[7:4]};
            n.status_word = nzf(cpu_r.status_word, n.a);
          end
          // second byte is the data, flags untouched
          8'he4:
          begin
            n.wa[0] = ea;
            n.wd[0] = cpu_r.b2;
            n.nwr = 2'd1;
          end
          // store at X, then step X
          8'hfb:
          begin
            n.wa[0] = {pg, cpu_r.x};
            n.wd[0] = cpu_r.a;
            n.nwr = 2'd1;
            n.x = cpu_r.x + 8'h01;
          end
          8'h1d:
          begin
            s17 = {1'b0, cpu_r.y, cpu_r.a} + {1'b0, wdp};
            h13 = {1'b0, cpu_r.y[3:0], cpu_r.a} + {1'b0, wdp[11:0]};
            {n.y, n.a} = s17[15:0];
            n.status_word[F_N] = s17[15];
            n.status_word[F_V] = ~(cpu_r.y[7] ^ wdp[15]) & (cpu_r.y[7] ^ s17[15]);
            n.status_word[F_H] = h13[12];
            n.status_word[F_Z] = (s17[15:0] == 16'h0000);
            n.status_word[F_C] = s17[16];
          end
          8'h5d:
          begin
            s17 = {1'b0, cpu_r.y, cpu_r.a} + {1'b0, ~wdp} + 17'h00001;
            n.status_word[F_N] = s17[15];
            n.status_word[F_Z] = (s17[15:0] == 16'h0000);
            n.status_word[F_C] = s17[16];
          end
          8'h0c, 8'h1c:
          begin
            n.status_word[F_Z] = ((cpu_r.a & src) == 8'h00);
            n.status_word[F_N] = src[7];
            n.status_word[F_V] = src[6];
          end
          // second byte: bit number, invert, high address
          8'h8b:
          begin
            bitv = src[cpu_r.b2[7:5]] ^ cpu_r.b2[4];
            n.status_word[F_C] = cpu_r.status_word[F_C] & bitv;
          end
          // flags from A - M, then clear A's bits in M
          8'h5c:
          begin
            n.status_word = nzf(cpu_r.status_word, cpu_r.a - src);
            n.wa[0] = ea;
            n.wd[0] = src & ~cpu_r.a;
            n.nwr = 2'd1;
          end
          // flag chosen by bits 6:5, polarity by bit 7
          8'b???10000:
          begin
            rel = cpu_r.b1;
            case (op[6:5])
              2'b00: bitv = cpu_r.status_word[F_N];
              2'b01: bitv = cpu_r.status_word[F_V];
              2'b10: bitv = cpu_r.status_word[F_C];
              default: bitv = cpu_r.status_word[F_Z];
            endcase
            taken = (bitv == op[7]);
          end
          8'h2f: n.pc = cpu_r.pc + {{8{cpu_r.b1[7]}}, cpu_r.b1};
          8'hfd, 8'h8d: taken = (cpu_r.a != src);
          8'hac:
          begin
            res8 = src - 8'h01;
            n.wa[0] = ea;
            n.wd[0] = res8;
            n.nwr = 2'd1;
            taken = (res8 != 8'h00);
          end
          8'h7b:
          begin
            rel = cpu_r.b1;
            n.y = cpu_r.y - 8'h01;
            taken = (n.y != 8'h00);
          end
          // push high then low, sp steps down after each
          8'h3b, 8'h5f:
          begin
            n.wa[0] = {STACK_PAGE, cpu_r.sp};
            n.wd[0] = cpu_r.pc[15:8];
            n.wa[1] = {STACK_PAGE, cpu_r.sp - 8'h01};
            n.wd[1] = cpu_r.pc[7:0];
            n.nwr = 2'd2;
            n.sp = cpu_r.sp - 8'h02;
            // bit 2 set marks the vector form, clear the absolute form
            n.pc = op[2] ? wdp : {cpu_r.b2, cpu_r.b1};
          end
          // push high, low, status with B set; I cleared
          8'h0f:
          begin
            n.wa[0] = {STACK_PAGE, cpu_r.sp};
            n.wd[0] = cpu_r.pc[15:8];
            n.wa[1] = {STACK_PAGE, cpu_r.sp - 8'h01};
            n.wd[1] = cpu_r.pc[7:0];
            n.wa[2] = {STACK_PAGE, cpu_r.sp - 8'h02};
            n.wd[2] = cpu_r.status_word | 8'h10;
            n.nwr = 2'd3;
            n.sp = cpu_r.sp - 8'h03;
            n.status_word[F_B] = 1'b1;
            n.status_word[F_I] = 1'b0;
            n.pc = wdp;
          end
          8'h7f:
          begin
            n.status_word = cpu_r.d[0];
            n.pc = {cpu_r.d[2], cpu_r.d[1]};
            n.sp = cpu_r.sp + 8'h03;
          end
          8'hef: n.stop = 1'b1;
          // bit 4 clear branches on one, set on zero
          8'h?2, 8'h?3:
          begin
            rel = op[0] ? cpu_r.b2 : cpu_r.b1;
            bitv = op[0] ? src[op[7:5]] : cpu_r.a[op[7:5]];
            taken = bitv ^ op[4];
          end
          default: n.nwr = 2'd0;
        endcase
        // write back single-operand results
        if (st8)
        begin
          case (op)
            8'ha8, 8'h88, 8'h48, 8'h28, 8'h68: n.a = res8;
            8'haf, 8'h8f: n.x = res8;
            8'hbe, 8'h9e: n.y = res8;
            default:
            begin
              n.wa[0] = ea;
              n.wd[0] = res8;
              n.nwr = 2'd1;
            end
          endcase
        end
        n.tgt = dc.cyc;
        // taken branch costs two more cycles
        if (taken)
        begin
          n.pc = cpu_r.pc + {{8{rel[7]}}, rel};
          n.tgt = dc.cyc + BR_EXTRA;
        end
        n.state = (n.nwr != 2'd0) ? S_WR : S_WAIT;
      end
      // writes issue in list order, one per cycle
      S_WR:
      begin
        n.mem = '{addr: cpu_r.wa[cpu_r.idx], wdata: cpu_r.wd[cpu_r.idx],
                  we: 1'b1, re: 1'b0};
        n.idx = cpu_r.idx + 2'd1;
        if (n.idx == cpu_r.nwr)
        begin
          n.state = S_WAIT;
        end
      end
      // pad to the instruction's cycle count
      S_WAIT:
      begin
        if (cpu_r.clk == lim)
        begin
          n.clk = 6'd0;
          n.state = cpu_r.stop ? S_STOP : S_FETCH;
        end
      end
      // only reset leaves the halted state
      S_STOP: n.clk = 6'd0;
      default: n.state = S_FETCH;
    endcase
    n.halt = (n.state == S_STOP);
  end

  // core registers
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      cpu_r <= CPU_RST;
    end
    else
    begin
      cpu_r <= n;
    end
  end

  assign memReq = cpu_r.mem;
  assign oscStop = cpu_r.halt;

  ////////////////////////////////////////////////////////////////////////
  // checks

  logic [7:0] insClk;  // clocks since the last fetch
  logic ex;

  always_ff @(posedge clk_sys)
  begin
    insClk <= (sys_rst || cpu_r.state == S_FETCH) ? 8'h01 : insClk + 8'h01;
  end

  assign ex = (cpu_r.state == S_EXEC);

  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  dec_flags_a:
  assert property (ex && op == 8'ha8 |=> cpu_r.a == $past(cpu_r.a) - 8'h01
    && cpu_r.status_word[F_C] == $past(cpu_r.status_word[F_C])) else $error("dec bad");
  inc_carry_a:
  assert property (ex && op == 8'h88 |=>
    cpu_r.status_word[F_C] == ($past(cpu_r.a) == 8'hff)) else $error("inc bad");
  right_shift_a:
  assert property (ex && op == 8'h48 |=> cpu_r.a == {1'b0, $past(cpu_r.a[7:1])}
    && cpu_r.status_word[F_C] == $past(cpu_r.a[0])) else $error("shift bad");
  product_word_a:
  assert property (ex && op == 8'h5b |=> {cpu_r.y, cpu_r.a} ==
    16'($past(cpu_r.y)) * 16'($past(cpu_r.a))) else $error("product bad");
  imm_store_a:
  assert property (ex && op == 8'he4 |=> cpu_r.status_word == $past(cpu_r.status_word)
    ##1 (cpu_r.mem.we && cpu_r.mem.wdata == $past(cpu_r.b2, 2)))
    else $error("immediate store bad");
  x_incr_a:
  assert property (ex && op == 8'hfb |=> cpu_r.x == $past(cpu_r.x) + 8'h01)
    else $error("x step bad");
  instr_len_a:
  assert property (cpu_r.state == S_WAIT && n.state != S_WAIT |->
    insClk + 8'h01 == 8'(32'(cpu_r.tgt) * MCYC)) else $error("length bad");
  trap_flags_a:
  assert property (ex && op == 8'h0f |=> !cpu_r.status_word[F_I] && cpu_r.status_word[F_B]
    && cpu_r.sp == $past(cpu_r.sp) - 8'h03) else $error("trap bad");
  trap_return_a:
  assert property (ex && op == 8'h7f |=> cpu_r.sp == $past(cpu_r.sp) + 8'h03)
    else $error("return bad");
  halt_hold_a:
  assert property (cpu_r.state == S_STOP |=> cpu_r.state == S_STOP && oscStop)
    else $error("halt bad");

  cover property (ex && op == 8'h0f);
  cover property (ex && op == 8'h50 && !cpu_r.status_word[F_C]);
  cover property (cpu_r.state == S_STOP);
  cover property (ex && op == 8'h7f);

endmodule : cis_core

/* File: bench/cis_mem_model.sv */
`timescale 1ns/10ps
module cis_mem_model
  import cis_pkg::*;
(
  input wire logic clk_sys,
  input wire cis_memreq_type memReq,
  output logic [7:0] memRdata
);
  // whole unified map, loaded by the bench
  logic [7:0] mem [0:65535];
  // last byte handed out
  logic [7:0] lastRd = 8'h00;
  //////////////////////////////////////////////////////////////
  // zero-latency read; idle bus shows the inverse, never a stale byte
  always_comb
  begin
    if (memReq.re)
      memRdata = mem[memReq.addr];
    else
      memRdata = ~lastRd;
  end
  // writes commit at the end of the request cycle
  always @(posedge clk_sys)
  begin
    if (memReq.we)
      mem[memReq.addr] <= memReq.wdata;
    if (memReq.re)
      lastRd <= mem[memReq.addr];
  end
endmodule : cis_mem_model

/* File: bench/testbench.sv */
`timescale 1ns/10ps
module testbench
  import cis_pkg::*;
;
  localparam int MC = 4;
  // program: store, load, subtract, swap, load, store+, inc, dec, product, shift,
  // trap
  localparam logic [7:0] IMG [0:15] = '{8'he4, 8'h30, 8'hf0, 8'hc4,
    8'h35, 8'h24, 8'h10, 8'hce, 8'h1e, 8'h20, 8'hfb, 8'h8f, 8'hbe,
    8'h5b, 8'h48, 8'h0f};
  // subroutine at 0300: branch over two halts, then trap return
  localparam logic [7:0] SUB [0:4] = '{8'h50, 8'h02, 8'hef, 8'hef, 8'h7f};
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic oscStop;
  cis_memreq_type memReq;
  logic [7:0] memRdata;
  logic [31:0] rd;
  logic err;
  int bad_count = 0;
  int checked = 0;
  int clkCnt = 0;
  int tFirst = -1;
  int tTrap = -1;
  int n;

  cis_core #(.MCYC(MC)) cis_core_inst (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .memReq(memReq), .memRdata(memRdata),
    .oscStop(oscStop));
  cis_mem_model cis_mem_model_inst (.clk_sys(clk_sys), .memReq(memReq),
    .memRdata(memRdata));

  always #5 clk_sys = ~clk_sys;
  //////////////////////////////////////////////////////////////
  // stamp first fetch and the trap handler fetch
  always @(posedge clk_sys)
  begin
    clkCnt <= clkCnt + 1;
    if (memReq.re === 1'b1 && memReq.addr === 16'h0000 && tFirst < 0)
      tFirst <= clkCnt;
    if (memReq.re === 1'b1 && memReq.addr === 16'h0200 && tTrap < 0)
      tTrap <= clkCnt;
  end
  // compare and count
  task automatic check(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] adr,
    input logic [31:0] wd, output logic [31:0] rdv, output logic errv);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= adr;
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    // only the watchdog ends a wait that never gets an answer
    do
    begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb
  // verdict
  task automatic end_sim;
    $display("counts checked %0d bad %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_sim
  // hang guard, well past the program length
  initial
  begin
    repeat (5000) @(posedge clk_sys);
    bad_count++;
    end_sim;
  end
  initial
  begin
    foreach (IMG[i]) cis_mem_model_inst.mem[i] = IMG[i];
    cis_mem_model_inst.mem[16'hffde] = 8'h00;
    cis_mem_model_inst.mem[16'hffdf] = 8'h02;
    // trap handler calls 0300; the return pops the call's bytes as status
    // and low address, the trap's status as high address: pc 1802
    cis_mem_model_inst.mem[16'h0200] = 8'h3b;
    cis_mem_model_inst.mem[16'h0201] = 8'h00;
    cis_mem_model_inst.mem[16'h0202] = 8'h03;
    foreach (SUB[i]) cis_mem_model_inst.mem[16'h0300 + i] = SUB[i];
    cis_mem_model_inst.mem[16'h1802] = 8'hef;
    repeat (6) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    apb(1'b0, REG_CTRL, 32'h0, rd, err);
    check("ctrl", rd, 32'h1);
    apb(1'b0, 12'h00c, 32'h0, rd, err);
    check("unmapped", {31'h0, err}, 32'h1);
    apb(1'b1, REG_CTRL, 32'h1, rd, err);
    check("ctrl wr", {31'h0, err}, 32'h0);
    $display("test bus done");
    n = 0;
    while (oscStop !== 1'b1 && n < 2000)
    begin
      @(posedge clk_sys);
      n++;
    end
    check("halt", {31'h0, oscStop}, 32'h1);
    apb(1'b0, REG_STAT, 32'h0, rd, err);
    check("halted", {31'h0, rd[16]}, 32'h1);
    check("return pc", rd[15:0], 32'h1803);
    // status word comes back from the stack pop; H stays masked
    apb(1'b0, REG_CORE, 32'h0, rd, err);
    check("core", rd & 32'hf7ffffff, 32'h0341_225f);
    check("dp store", cis_mem_model_inst.mem[16'h0030], 32'hf0);
    check("x store", cis_mem_model_inst.mem[16'h0020], 32'h42);
    check("push hi", cis_mem_model_inst.mem[16'h01ff], 32'h00);
    check("push lo", cis_mem_model_inst.mem[16'h01fe], 32'h10);
    check("call hi", cis_mem_model_inst.mem[16'h01fc], 32'h02);
    check("call lo", cis_mem_model_inst.mem[16'h01fb], 32'h03);
    check("push psw", cis_mem_model_inst.mem[16'h01fd] & 8'hf7,
      32'h10);
    check("cycles", tTrap - tFirst, 43 * MC);
    $display("test program done");
    end_sim;
  end
endmodule : testbench
